/* File: shared/sas_pkg.sv */
`default_nettype none
package sas_pkg;
   // register byte addresses (low byte of each 16-bit word)
   localparam logic [6:0] OFS_FILT  = 7'h38;
   localparam logic [6:0] OFS_SLEEP = 7'h3a;
   localparam logic [6:0] OFS_STAT  = 7'h3c;
   // reset values and limits
   localparam logic [3:0] FILT_RST  = 4'h4;
   localparam logic [3:0] FILT_MAX  = 4'h8;
   localparam logic [7:0] SLEEP_RST = 8'h00;
   localparam logic [15:0] STAT_RST = 16'h0000;
   // status bit positions
   localparam int ST_ALM2 = 9;
   localparam int ST_ALM1 = 8;
   localparam int ST_COMM = 3;
   localparam int ST_UPD  = 2;
   localparam int ST_VHI  = 1;
   localparam int ST_VLO  = 0;
   // frame layout
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam int FR_WRITE = 15;
   // channels and filter depth
   localparam int NUM_CH   = 7;
   localparam int MAX_TAPS = 256;
   // timing
   localparam int CLK_NS      = 10;
   localparam int HALF_SEC_MS = 500;
   localparam int RECOVER_MS  = 2;
   localparam int HALF_SEC_CYC = HALF_SEC_MS * 1000000 / CLK_NS;
   localparam int RECOVER_CYC  = RECOVER_MS * 1000000 / CLK_NS;
   typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_RECOVER} sas_pwr_e;
endpackage
`default_nettype wire

/* File: rtl/sas_sensor_avg_sleep_status.sv */
// How it works
// R1 - one filter setting applies to all seven outputs together
// R2 - tap count is two to the exponent; zero passes samples straight
// R3 - exponent at most eight (256 taps); larger writes are refused
// R4 - output is sum of last N samples divided by N
// R5 - exponent sits in bits 3:0; bits 15:4 read zero
// R6 - exponent resets to four, sixteen taps
// R7 - sleep field is eight bits, interval is value times half a second
// R8 - zero disables sleep; nonzero sleeps after the current update
// R9 - sleep field resets to zero and clears on sleep entry
// R10 - only timeout or reset wakes; serial access never does
// R11 - after timeout wait two ms before next conversion
// R12 - sleep entry clears new data flags and data ready
// R13 - control settings and output data survive sleep
// R14 - auxiliary converter powered down while asleep
// R15 - status read clears flags; they set again while condition persists
// R16 - bit 9 alarm two, bit 8 alarm one, 15:10 zero
// R17 - bit 3 serial failure, bit 2 update failure, 7:4 zero
// R18 - bit 1 supply high, bit 0 supply low
// R19 - all outputs update together once per sample tick; with an accepted filter write in the same cycle dataOut does not update
// R20 - half second time base counts the sleep interval down
`timescale 1ns/1ns
`default_nettype none
module sas_sensor_avg_sleep_status #(
   parameter int DW           = 14,
   parameter int HALF_SEC_CYC = sas_pkg::HALF_SEC_CYC,
   parameter int RECOVER_CYC  = sas_pkg::RECOVER_CYC
) (
   // clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rst,
   // serial port, mode 3
   input  wire logic                                  sclk,
   input  wire logic                                  csN,
   input  wire logic                                  mosi,
   output var  logic                                  miso,
   // sample path
   input  wire logic                                  sampleTick,
   input  wire logic [sas_pkg::NUM_CH-1:0][DW-1:0]    sampleIn,
   output var  logic [sas_pkg::NUM_CH-1:0][DW-1:0]    dataOut,
   output var  logic [sas_pkg::NUM_CH-1:0]            newData,
   output var  logic                                  dataReady,
   // monitors
   input  wire logic                                  alarm1,
   input  wire logic                                  alarm2,
   input  wire logic                                  supplyHigh,
   input  wire logic                                  supplyLow,
   // power
   output var  logic                                  dacPowerDown,
   output var  logic                                  asleep
);
   localparam int NC = sas_pkg::NUM_CH;
   localparam int SW = DW + 8;

   function automatic logic [15:0] readWord(input logic [6:0] a, input logic [3:0] fe,
                                            input logic [7:0] sd, input logic [15:0] st);
      case ({a[6:1], 1'b0})
         sas_pkg::OFS_FILT:  readWord = {12'h000, fe};      // R5
         sas_pkg::OFS_SLEEP: readWord = {8'h00, sd};
         sas_pkg::OFS_STAT:  readWord = st;
         default:            readWord = 16'h0000;
      endcase
   endfunction

   // ---------------- serial port ----------------
   logic [2:0]  sclkSync_reg, sclkSync_next;
   logic [2:0]  csSync_reg, csSync_next;
   logic [1:0]  mosiSync_reg, mosiSync_next;
   logic [15:0] rxShift_reg, rxShift_next;
   logic [15:0] txShift_reg, txShift_next;
   logic [4:0]  bitCnt_reg, bitCnt_next;
   logic        miso_reg, miso_next;
   logic        sclkRise, sclkFall, frameStart, frameEnd, frameOk, commFail;
   logic        wrReq, rdReq, statusRd;
   logic [6:0]  reqAddr;
   logic [7:0]  reqData;

   logic [3:0]  filtExp_reg, filtExp_next;
   logic [7:0]  sleep_reg, sleep_next;
   logic [15:0] status_reg, status_next;

   always_comb begin
      sclkSync_next = {sclkSync_reg[1:0], sclk};
      csSync_next   = {csSync_reg[1:0], csN};
      mosiSync_next = {mosiSync_reg[0], mosi};
      sclkRise   = sclkSync_reg[1] & ~sclkSync_reg[2];
      sclkFall   = ~sclkSync_reg[1] & sclkSync_reg[2];
      frameStart = ~csSync_reg[1] & csSync_reg[2];
      frameEnd   = csSync_reg[1] & ~csSync_reg[2];
      frameOk    = frameEnd && (bitCnt_reg == sas_pkg::FRAME_BITS);
      commFail   = frameEnd && (bitCnt_reg != sas_pkg::FRAME_BITS);
      reqAddr    = rxShift_reg[14:8];
      reqData    = rxShift_reg[7:0];
      wrReq      = frameOk & rxShift_reg[sas_pkg::FR_WRITE];
      rdReq      = frameOk & ~rxShift_reg[sas_pkg::FR_WRITE];
      statusRd   = rdReq && (reqAddr[6:1] == sas_pkg::OFS_STAT[6:1]);
      rxShift_next = rxShift_reg;
      txShift_next = txShift_reg;
      bitCnt_next  = bitCnt_reg;
      if (frameStart) begin
         bitCnt_next = 5'h00;
      end else if (sclkRise && !csSync_reg[1]) begin
         rxShift_next = {rxShift_reg[14:0], mosiSync_reg[1]};
         bitCnt_next  = (bitCnt_reg == 5'h1f) ? bitCnt_reg : bitCnt_reg + 5'h01;
      end else if (sclkFall && !csSync_reg[1] && bitCnt_reg != 5'h00) begin
         // idle-high clock: first falling edge must not drop the msb
         txShift_next = {txShift_reg[14:0], 1'b0};
      end
      // answer goes out during the following frame
      if (rdReq) begin
         txShift_next = readWord(reqAddr, filtExp_reg, sleep_reg, status_reg);
      end
      miso_next = txShift_reg[15];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclkSync_reg <= 3'h7;
         csSync_reg   <= 3'h7;
         mosiSync_reg <= 2'h0;
         rxShift_reg  <= 16'h0000;
         txShift_reg  <= 16'h0000;
         bitCnt_reg   <= 5'h00;
         miso_reg     <= 1'b0;
      end else begin
         sclkSync_reg <= sclkSync_next;
         csSync_reg   <= csSync_next;
         mosiSync_reg <= mosiSync_next;
         rxShift_reg  <= rxShift_next;
         txShift_reg  <= txShift_next;
         bitCnt_reg   <= bitCnt_next;
         miso_reg     <= miso_next;
      end
   end

   // ---------------- control, status, power ----------------
   sas_pkg::sas_pwr_e state_reg, state_next;
   logic [31:0]   pre_reg, pre_next;
   logic [7:0]    left_reg, left_next;
   logic [31:0]   rec_reg, rec_next;
   logic [NC-1:0] newFlag_reg, newFlag_next;
   logic          drdy_reg, drdy_next;
   logic          dac_reg, dac_next;
   logic          asleep_reg, asleep_next;
   logic          update, restart, updFail;
   logic [15:0]   statSet;

   always_comb begin
      filtExp_next = filtExp_reg;
      sleep_next   = sleep_reg;
      state_next   = state_reg;
      pre_next     = pre_reg;
      left_next    = left_reg;
      rec_next     = rec_reg;
      newFlag_next = newFlag_reg;
      drdy_next    = 1'b0;
      dac_next     = dac_reg;
      restart      = 1'b0;
      updFail      = 1'b0;
      update       = (state_reg == sas_pkg::PWR_RUN) & sampleTick;   // R19
      // writes land in any state but never change the power state
      if (wrReq) begin   // R10
         case (reqAddr)
            sas_pkg::OFS_FILT: begin
               if (reqData <= 8'(sas_pkg::FILT_MAX)) begin   // R3
                  filtExp_next = reqData[3:0];   // R1
                  restart      = 1'b1;
               end else begin
                  updFail = 1'b1;   // R17
               end
            end
            sas_pkg::OFS_SLEEP: sleep_next = reqData;   // R7
            default: ;
         endcase
      end
      case (state_reg)
         sas_pkg::PWR_RUN: begin
            if (update) begin
               newFlag_next = '1;
               drdy_next = 1'b1;
               if (sleep_reg != 8'h00) begin   // R8
                  state_next = sas_pkg::PWR_SLEEP;
                  sleep_next = 8'h00;   // R9
                  left_next  = sleep_reg;
                  pre_next   = 32'h0;
                  newFlag_next = '0;   // R12
                  drdy_next  = 1'b0;   // R12
                  dac_next   = 1'b1;   // R14
               end
            end
         end
         sas_pkg::PWR_SLEEP: begin
            pre_next = pre_reg + 32'h1;
            if (pre_reg == 32'(HALF_SEC_CYC - 1)) begin   // R20
               pre_next = 32'h0;
               if (left_reg == 8'h01) begin
                  state_next = sas_pkg::PWR_RECOVER;
                  rec_next   = 32'h0;
                  dac_next   = 1'b0;
               end else begin
                  left_next = left_reg - 8'h01;
               end
            end
         end
         sas_pkg::PWR_RECOVER: begin
            rec_next = rec_reg + 32'h1;
            if (rec_reg == 32'(RECOVER_CYC - 1)) begin   // R11
               state_next = sas_pkg::PWR_RUN;
            end
         end
         default: state_next = sas_pkg::PWR_RUN;
      endcase
      asleep_next = (state_next == sas_pkg::PWR_SLEEP);
      // conditions re-evaluated each update; events set at once
      statSet = 16'h0000;
      statSet[sas_pkg::ST_ALM2] = update & alarm2;   // R16
      statSet[sas_pkg::ST_ALM1] = update & alarm1;   // R16
      statSet[sas_pkg::ST_VHI]  = update & supplyHigh;   // R18
      statSet[sas_pkg::ST_VLO]  = update & supplyLow;   // R18
      statSet[sas_pkg::ST_COMM] = commFail;   // R17
      statSet[sas_pkg::ST_UPD]  = updFail;   // R17
      // set beats the read that clears
      status_next = (statusRd ? 16'h0000 : status_reg) | statSet;   // R15
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filtExp_reg <= sas_pkg::FILT_RST;   // R6
         sleep_reg   <= sas_pkg::SLEEP_RST;   // R9
         status_reg  <= sas_pkg::STAT_RST;
         state_reg   <= sas_pkg::PWR_RUN;
         pre_reg     <= 32'h0;
         left_reg    <= 8'h00;
         rec_reg     <= 32'h0;
         newFlag_reg <= '0;
         drdy_reg    <= 1'b0;
         dac_reg     <= 1'b0;
         asleep_reg  <= 1'b0;
      end else begin
         filtExp_reg <= filtExp_next;
         sleep_reg   <= sleep_next;
         status_reg  <= status_next;
         state_reg   <= state_next;
         pre_reg     <= pre_next;
         left_reg    <= left_next;
         rec_reg     <= rec_next;
         newFlag_reg <= newFlag_next;
         drdy_reg    <= drdy_next;
         dac_reg     <= dac_next;
         asleep_reg  <= asleep_next;
      end
   end

   // ---------------- moving average ----------------
   // history is flops; outputs read low until N samples have arrived
   logic [DW-1:0] hist_reg [NC][sas_pkg::MAX_TAPS];
   logic [DW-1:0] hist_next [NC][sas_pkg::MAX_TAPS];
   logic [NC-1:0][SW-1:0] sum_reg, sum_next;
   logic [NC-1:0][DW-1:0] out_reg, out_next;
   logic [7:0] wr_reg, wr_next;
   logic [8:0] fill_reg, fill_next;
   logic [8:0] taps;

   always_comb begin
      hist_next = hist_reg;
      sum_next  = sum_reg;
      out_next  = out_reg;
      wr_next   = wr_reg;
      fill_next = fill_reg;
      taps      = 9'h001 << filtExp_reg;   // R2
      if (restart) begin
         sum_next  = '0;
         fill_next = 9'h000;
      end else if (update) begin
         for (int ch = 0; ch < NC; ch++) begin   // R1
            sum_next[ch] = sum_reg[ch] + SW'(sampleIn[ch])
                         - ((fill_reg >= taps) ? SW'(hist_reg[ch][wr_reg - taps[7:0]]) : SW'(0));
            hist_next[ch][wr_reg] = sampleIn[ch];
            out_next[ch] = DW'(sum_next[ch] >> filtExp_reg);   // R4
         end
         wr_next   = wr_reg + 8'h01;
         fill_next = (fill_reg == 9'(sas_pkg::MAX_TAPS)) ? fill_reg : fill_reg + 9'h001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hist_reg <= '{default: '{default: '0}};
         sum_reg  <= '0;
         out_reg  <= '0;
         wr_reg   <= 8'h00;
         fill_reg <= 9'h000;
      end else begin
         hist_reg <= hist_next;
         sum_reg  <= sum_next;
         out_reg  <= out_next;   // R13
         wr_reg   <= wr_next;
         fill_reg <= fill_next;
      end
   end

   assign miso         = miso_reg;
   assign dataOut      = out_reg;
   assign newData      = newFlag_reg;
   assign dataReady    = drdy_reg;
   assign dacPowerDown = dac_reg;
   assign asleep       = asleep_reg;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic sleeping;
   assign sleeping = (state_reg == sas_pkg::PWR_SLEEP);

   property p_exp_max;
      filtExp_reg <= sas_pkg::FILT_MAX;
   endproperty
   a_exp_max: assert property (p_exp_max) else $error("filter exponent above eight");   // R3
   property p_bad_exp;
      wrReq && reqAddr == sas_pkg::OFS_FILT && reqData > 8'h08 |=> $stable(filtExp_reg) && status_reg[2];
   endproperty
   a_bad_exp: assert property (p_bad_exp) else $error("bad exponent not refused");   // R17
   property p_enter;
      update && sleep_reg != 8'h00 |=> sleeping && sleep_reg == 8'h00 && newData == '0 && !dataReady;
   endproperty
   a_enter: assert property (p_enter) else $error("sleep entry wrong");   // R8
   property p_dac;
      sleeping |-> dacPowerDown;
   endproperty
   a_dac: assert property (p_dac) else $error("dac awake while sleeping");   // R14
   property p_hold;
      sleeping ##1 sleeping |-> $stable(dataOut) && newData == '0;
   endproperty
   a_hold: assert property (p_hold) else $error("outputs moved in sleep");   // R13
   property p_stay;
      sleeping && (left_reg > 8'h01 || pre_reg != 32'(HALF_SEC_CYC - 1)) |=> sleeping;
   endproperty
   a_stay: assert property (p_stay) else $error("early wake");   // R10
   property p_recover;
      sleeping ##1 !sleeping |-> state_reg == sas_pkg::PWR_RECOVER;
   endproperty
   a_recover: assert property (p_recover) else $error("wake skipped recovery");   // R11
   property p_update;
      update |=> newData == '1 || sleeping;
   endproperty
   a_update: assert property (p_update) else $error("outputs not updated together");   // R19
   property p_pass;
      update && !restart && filtExp_reg == 4'h0 |=> dataOut[0] == $past(sampleIn[0]);
   endproperty
   a_pass: assert property (p_pass) else $error("single tap not pass-through");   // R2
   property p_clear;
      statusRd && statSet == 16'h0000 |=> status_reg == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("status read did not clear");   // R15
   property p_comm;
      commFail |=> status_reg[3];
   endproperty
   a_comm: assert property (p_comm) else $error("serial failure not flagged");   // R17

   property p_cv_sleep;
      sleeping ##1 !sleeping;
   endproperty
   c_cv_sleep: cover property (p_cv_sleep);
   property p_cv_read;
      statusRd && status_reg != 16'h0000;
   endproperty
   c_cv_read: cover property (p_cv_read);
   property p_cv_exp;
      restart && filtExp_next == 4'h8;
   endproperty
   c_cv_exp: cover property (p_cv_exp);
endmodule
`default_nettype wire

/* File: testbench/sas_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sas_host_model (
   // clock
   input  wire logic clk,
   // serial port
   output var  logic sclk,
   output var  logic csN,
   output var  logic mosi,
   input  wire logic miso
);
   initial begin
      sclk = 1'b1;
      csN  = 1'b1;
      mosi = 1'b0;
   end
   // n bits msb first; four clocks per half period keeps the synchronisers happy
   // exponent values are only those the bench commands; an illegal one is a deliberate refusal test
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(negedge clk) csN = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 15; i > 15 - n; i--) begin
         sclk = 1'b0;
         mosi = tx[i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         rx = {rx[14:0], miso};
      end
      csN = 1'b1;
      // released line must not keep showing the last bit
      mosi = ~mosi;
      repeat (6) @(negedge clk);
   endtask
endmodule
`default_nettype wire

/* File: testbench/sas_sensor_avg_sleep_status_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module sas_sensor_avg_sleep_status_tb;
   localparam int DW = 14;
   localparam int HS = 200;
   localparam int RC = 10;
   logic                        clk = 1'b0;
   logic                        rst = 1'b1;
   logic                        sclk, csN, mosi, miso;
   logic                        sampleTick = 1'b0;
   logic [6:0][DW-1:0]          sampleIn = '0;
   logic [6:0][DW-1:0]          dataOut;
   logic [6:0]                  newData;
   logic                        dataReady, dacPowerDown, asleep;
   logic                        alarm1 = 1'b0, alarm2 = 1'b0, supplyHigh = 1'b0, supplyLow = 1'b0;
   logic [15:0]                 rv;
   int                          err_count = 0, total_checks = 0, cyc = 0, sleepCyc = 0, drdy = 0;
   int                          sleepAt = 0, drdyAt = 0;

   always #5 clk = ~clk;

   sas_sensor_avg_sleep_status #(.DW(DW), .HALF_SEC_CYC(HS), .RECOVER_CYC(RC)) uut (
      .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
      .sampleTick(sampleTick), .sampleIn(sampleIn), .dataOut(dataOut), .newData(newData),
      .dataReady(dataReady), .alarm1(alarm1), .alarm2(alarm2), .supplyHigh(supplyHigh),
      .supplyLow(supplyLow), .dacPowerDown(dacPowerDown), .asleep(asleep));

   sas_host_model host (.clk(clk), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (asleep === 1'b1) sleepCyc <= sleepCyc + 1;
      if (dataReady === 1'b1) drdy <= drdy + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] rx;
      host.xfer({1'b1, a, d}, 16, rx);
   endtask

   // the answer to a read arrives in the following frame
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      logic [15:0] rx;
      host.xfer({1'b0, a, 8'h00}, 16, rx);
      host.xfer(16'h0000, 16, d);
   endtask

   task automatic tick(input logic [DW-1:0] base);
      @(negedge clk);
      for (int i = 0; i < 7; i++) sampleIn[i] = base + DW'(i);
      sampleTick = 1'b1;
      @(negedge clk) sampleTick = 1'b0;
      @(negedge clk);
   endtask

   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      rd(sas_pkg::OFS_FILT, rv);  check("filt", rv, 16'h0004);
      rd(sas_pkg::OFS_SLEEP, rv); check("sleep", rv, 16'h0000);
      rd(sas_pkg::OFS_STAT, rv);  check("stat", rv, 16'h0000);
      $display("test reset done");

      wr(sas_pkg::OFS_FILT, 8'h00);
      tick(14'h0123);
      for (int i = 0; i < 7; i++) check("dout", dataOut[i], 32'h123 + i);
      check("newData", newData, 7'h7f);
      check("drdy", drdy, 1);
      check("asleep", asleep, 1'b0);
      wr(sas_pkg::OFS_FILT, 8'h01);
      tick(14'd100);
      tick(14'd200);
      for (int i = 0; i < 7; i++) check("avg", dataOut[i], 150 + i);
      $display("test filter done");

      wr(sas_pkg::OFS_FILT, 8'h08);
      rd(sas_pkg::OFS_FILT, rv); check("filt8", rv, 16'h0008);
      wr(sas_pkg::OFS_FILT, 8'h09);
      rd(sas_pkg::OFS_FILT, rv); check("filt9", rv, 16'h0008);
      rd(sas_pkg::OFS_STAT, rv); check("updFail", rv, 16'h0004);
      host.xfer(16'hffff, 8, rv);
      rd(sas_pkg::OFS_STAT, rv); check("commFail", rv, 16'h0008);
      $display("test refusal done");

      alarm1 = 1'b1; alarm2 = 1'b1; supplyHigh = 1'b1; supplyLow = 1'b1;
      tick(14'd0);
      alarm2 = 1'b0; supplyHigh = 1'b0; supplyLow = 1'b0;
      rd(sas_pkg::OFS_STAT, rv); check("statAll", rv, 16'h0303);
      rd(sas_pkg::OFS_STAT, rv); check("statClr", rv, 16'h0000);
      tick(14'd0);
      rd(sas_pkg::OFS_STAT, rv); check("statAgain", rv, 16'h0100);
      alarm1 = 1'b0;
      $display("test status done");

      wr(sas_pkg::OFS_FILT, 8'h02);
      wr(sas_pkg::OFS_SLEEP, 8'h02);
      rd(sas_pkg::OFS_SLEEP, rv); check("sleepRd", rv, 16'h0002);
      sleepAt = sleepCyc;
      drdyAt = drdy;
      tick(14'd300);
      for (int i = 0; i < 7; i++) check("dpre", dataOut[i], (300 + i) / 4);
      check("asleep", asleep, 1'b1);
      check("dacPd", dacPowerDown, 1'b1);
      check("newDataClr", newData, 7'h00);
      check("drdySl", drdy - drdyAt, 0);
      rd(sas_pkg::OFS_SLEEP, rv); check("sleepClr", rv, 16'h0000);
      check("stayAsleep", asleep, 1'b1);
      for (int k = 0; k < 1000 && asleep !== 1'b0; k++) @(negedge clk);
      check("sleepLen", sleepCyc - sleepAt, 2 * HS);
      check("dacUp", dacPowerDown, 1'b0);
      tick(14'd900);
      for (int i = 0; i < 7; i++) check("dkeep", dataOut[i], (300 + i) / 4);
      check("newDataRec", newData, 7'h00);
      repeat (RC + 2) @(negedge clk);
      tick(14'd900);
      check("newDataRun", newData, 7'h7f);
      rd(sas_pkg::OFS_FILT, rv); check("filtKeep", rv, 16'h0002);
      $display("test sleep done");

      wr(sas_pkg::OFS_SLEEP, 8'hff);
      tick(14'd0);
      check("asleep2", asleep, 1'b1);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      check("rstWake", asleep, 1'b0);
      repeat (3) @(negedge clk);
      rd(sas_pkg::OFS_FILT, rv); check("filtRst", rv, 16'h0004);
      $display("test reset wake done");
      give_verdict();
   end
endmodule
`default_nettype wire
